// file: rtl/ftsc_pkg.sv
// Constants for the flow-through burst SRAM bus control block.
// Assumes a single clock domain; widths fixed for the x36 organisation.
package ftsc_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 10;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BURST_W = 2;
  // ----------------------------------------
  // Sleep exit time
  // ----------------------------------------
  localparam int SLEEP_CYCLES = 2;
  // ----------------------------------------
  // Cycle kinds, Gray coded along the usual path
  // ----------------------------------------
  typedef enum logic [1:0] {
    FTSC_IDLE = 2'h0,
    FTSC_READ = 2'h1,
    FTSC_WRITE = 2'h3,
    FTSC_SLEEP = 2'h2
  } ftsc_state_t;
endpackage

// file: rtl/ftsc_burst_next.sv
// Burst address step on the two lowest address bits.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module ftsc_burst_next
  import ftsc_pkg::*;
(
  // Current low bits, burst start bits and order
  input wire logic [BURST_W-1:0] cur_i,
  input wire logic [BURST_W-1:0] start_i,
  input wire logic interleave_i,
  // Next low bits
  output logic [BURST_W-1:0] next_o
);
  logic [BURST_W-1:0] step;
  // Interleaved order is the start xor a step count; the count is recovered from the start
  always_comb begin
    step = cur_i ^ start_i;
    if (interleave_i) begin
      next_o = start_i ^ (step + 2'h1);
    end else begin
      next_o = cur_i + 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ftsc_sram_ctrl.sv
// Flow-through burst SRAM cycle control with its own storage array.
// Assumes controller inputs are synchronous to clk_i; sleep request is asynchronous.
// Summary of operation
// - Clock qualifier high: edge ignored, address and operation held.
// - Data and parity driven from current cycle, gated by asynchronous output enable.
// - Read drives data only with output enable active and part selected.
// - Any write cycle floats every data and parity pin.
// - Output enable masked internally during write cycles.
// - Powers up deselected, pins floating, regardless of output enable.
// - Write with all lane selects high aborts: nothing stored, pins float.
// - Each low lane select writes its byte and parity bit.
// - Any lane select pattern accepted; exactly selected lanes written.
// - Write strobe low alone selects a write, whatever the lane selects; write strobe high means read.
// - Advance high at enabled edge steps burst counter regardless of selects.
// - Burst order low linear, high interleaved, wrapping after four.
// - Write data and lane selects latched at the edge after the command.
// - Sleep request enters sleep at the fourth clock edge, outputs floating.
`timescale 1ns/1ps
`default_nettype none
module ftsc_sram_ctrl
  import ftsc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command inputs
  input wire logic clk_qualify_n_i,
  input wire logic chip_sel_1_n_i,
  input wire logic chip_sel_2_i,
  input wire logic chip_sel_3_n_i,
  input wire logic advance_or_load_i,
  input wire logic write_n_i,
  input wire logic [LANES-1:0] byte_lane_write_n_i,
  input wire logic burst_mode_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic out_enable_n_i,
  input wire logic sleep_request_i,
  // Data and parity pins
  input wire logic [DATA_W-1:0] data_in_i,
  output logic [DATA_W-1:0] data_out_o,
  output logic [DATA_W-1:0] data_oe_o,
  input wire logic [LANES-1:0] parity_io_in_i,
  output logic [LANES-1:0] parity_io_out_o,
  output logic [LANES-1:0] parity_io_oe_o,
  // Status
  output logic asleep_o
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [LANE_W:0] mem [LANES][DEPTH];
  ftsc_state_t state;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] wr_addr;
  logic wr_pend;
  logic burst_int;
  logic [BURST_W-1:0] burst_start;
  logic [BURST_W-1:0] next_low;
  logic [2:0] zz_sync;
  logic [1:0] zz_cnt;
  logic sleeping;
  logic selected;
  logic enabled;
  logic [DATA_W-1:0] rd_data;
  logic [LANES-1:0] rd_par;
  logic drive;

  assign selected = !chip_sel_1_n_i && chip_sel_2_i && !chip_sel_3_n_i;
  assign enabled = !clk_qualify_n_i && !sleeping;

  ftsc_burst_next u_next (
    .cur_i(addr[BURST_W-1:0]),
    .start_i(burst_start),
    .interleave_i(burst_int),
    .next_o(next_low)
  );

  // ----------------------------------------
  // Sleep synchroniser, four edge entry
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zz_sync <= 3'h0;
    end else begin
      zz_sync <= {zz_sync[1:0], sleep_request_i};
    end
  end

  // Third stage costs entry latency, traded for margin on an asynchronous pin
  // A level counts once the second and third stages agree
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      zz_cnt <= 2'h0;
      sleeping <= 1'b0;
    end else if (zz_sync[1] && zz_sync[2]) begin
      sleeping <= 1'b1;
      zz_cnt <= 2'h0;
    end else if (!zz_sync[1] && !zz_sync[2]) begin
      if (zz_cnt == 2'(SLEEP_CYCLES - 1)) begin
        sleeping <= 1'b0;
      end else if (sleeping) begin
        zz_cnt <= zz_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Cycle decode and burst address
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= FTSC_IDLE;
      addr <= '0;
      burst_int <= 1'b0;
      burst_start <= '0;
    end else if (sleeping) begin
      state <= FTSC_SLEEP;
    end else if (enabled) begin
      if (!advance_or_load_i) begin
        if (!selected) begin
          state <= FTSC_IDLE;
        end else begin
          state <= write_n_i ? FTSC_READ : FTSC_WRITE;
          addr <= addr_i;
          burst_int <= burst_mode_i;
          burst_start <= addr_i[BURST_W-1:0];
        end
      end else begin
        addr <= {addr[ADDR_W-1:BURST_W], next_low};
        if (state == FTSC_SLEEP) begin
          state <= FTSC_IDLE;
        end
      end
    end
  end

  // ----------------------------------------
  // Write data phase, one edge after command
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else if (enabled) begin
      wr_pend <= (!advance_or_load_i) ? (selected && !write_n_i)
        : (state == FTSC_WRITE);
      wr_addr <= (!advance_or_load_i) ? addr_i : {addr[ADDR_W-1:BURST_W], next_low};
    end
  end

  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge clk_i) begin
        if (enabled && wr_pend && !byte_lane_write_n_i[g]) begin
          mem[g][wr_addr] <= {parity_io_in_i[g], data_in_i[g*LANE_W +: LANE_W]};
        end
      end
      assign rd_data[g*LANE_W +: LANE_W] = mem[g][addr][LANE_W-1:0];
      assign rd_par[g] = mem[g][addr][LANE_W];
    end
  endgenerate

  // ----------------------------------------
  // Output drivers
  // ----------------------------------------
  // Output enable is combinational so it acts without the clock
  assign drive = (state == FTSC_READ) && !out_enable_n_i && !sleeping;
  assign data_out_o = rd_data;
  assign data_oe_o = {DATA_W{drive}};
  assign parity_io_out_o = rd_par;
  assign parity_io_oe_o = {LANES{drive}};
  assign asleep_o = sleeping;

  // ----------------------------------------
  // Checks on what the block drives, its cycle state and burst address
  // ----------------------------------------
  AST_WRITE_FLOATS: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == FTSC_WRITE) |-> (data_oe_o == '0 && parity_io_oe_o == '0))
    else $error("driving in write");
  AST_STALL_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
    (clk_qualify_n_i && !sleeping) |=> ($stable(addr) && $stable(state) && $stable(wr_pend)))
    else $error("stall moved state");
  AST_OE_GATES: assert property (@(posedge clk_i) disable iff (rst_i)
    out_enable_n_i |-> (data_oe_o == '0 && parity_io_oe_o == '0))
    else $error("drive without oe");
  AST_READ_DRIVES: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == FTSC_READ && !out_enable_n_i && !asleep_o) |-> (data_oe_o == '1))
    else $error("read not driven");
  AST_SLEEP_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(zz_sync[2]) |-> ##[0:2] asleep_o)
    else $error("slow sleep");
  AST_SLEEP_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep_o |-> (data_oe_o == '0 && parity_io_oe_o == '0))
    else $error("driving asleep");
  AST_ASLEEP_STATE: assert property (@(posedge clk_i) disable iff (rst_i)
    asleep_o |=> (state == FTSC_SLEEP))
    else $error("sleep state lost");
  AST_DESEL_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == FTSC_IDLE) |-> !drive)
    else $error("drive deselected");
  AST_DESEL_STAYS: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && advance_or_load_i && state == FTSC_IDLE) |=> (state == FTSC_IDLE))
    else $error("advance left deselect");
  AST_LOAD_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && !advance_or_load_i && selected) |=>
    (state == ($past(write_n_i) ? FTSC_READ : FTSC_WRITE)))
    else $error("load direction wrong");
  AST_WR_PHASE: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && !advance_or_load_i && selected && !write_n_i) |=> wr_pend)
    else $error("write phase lost");
  AST_DIR_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && advance_or_load_i && state == FTSC_READ) |=> (state == FTSC_READ))
    else $error("burst direction changed");
  AST_WDIR_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && advance_or_load_i && state == FTSC_WRITE) |=> (state == FTSC_WRITE && wr_pend))
    else $error("write burst direction changed");
  AST_BURST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && advance_or_load_i && !burst_int) |=>
    (addr[1:0] == $past(addr[1:0]) + 2'h1))
    else $error("burst step wrong");
  AST_BURST_ILV: assert property (@(posedge clk_i) disable iff (rst_i)
    (enabled && advance_or_load_i && burst_int) |=>
    ((addr[1:0] ^ burst_start) == (($past(addr[1:0]) ^ burst_start) + 2'h1)))
    else $error("interleaved step wrong");
endmodule
`default_nettype wire

// file: bench/ftsc_bus_model.sv
// Common data and parity bus as seen from the memory controller side.
// Assumes the bench tells it when the controller drives write data.
`timescale 1ns/1ps
`default_nettype none
module ftsc_bus_model
  import ftsc_pkg::*;
#(
  parameter int W = DATA_W + LANES
) (
  // Clock
  input wire logic clk_i,
  // Controller side
  input wire logic drive_i,
  input wire logic [W-1:0] ctl_i,
  // Device side
  input wire logic [W-1:0] dev_i,
  input wire logic [W-1:0] dev_oe_i,
  // Resolved pin levels
  output logic [W-1:0] pins_o
);
  logic [W-1:0] last;
  always_ff @(posedge clk_i) begin
    last <= pins_o;
  end
  // Undriven bits invert each cycle so a stale value never passes as data
  always_comb begin
    pins_o = (dev_oe_i & dev_i) | (~dev_oe_i & (drive_i ? ctl_i : ~last));
  end
endmodule
`default_nettype wire

// file: bench/flow_through_sram_bus_control_tb.sv
// Self-checking bench for the flow-through SRAM cycle control.
// Assumes the bus model resolves the shared pins.
`timescale 1ns/1ps
`default_nettype none
module flow_through_sram_bus_control_tb
  import ftsc_pkg::*;
;
  localparam int W = DATA_W + LANES;
  logic clk_i = 0, rst_i = 1, qn = 0, s1n = 1, s2 = 0, s3n = 1, adv = 0, wn = 1;
  logic bm = 0, oen = 0, slp = 0, den = 0, asl;
  logic [LANES-1:0] ln = '1;
  logic [ADDR_W-1:0] a = '0;
  logic [W-1:0] wd = '0, e;
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] q [$];
  wire [W-1:0] pins, dq, doe;
  int errors = 0, n_compared = 0, seed = 24723, i;
  ftsc_sram_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .clk_qualify_n_i(qn),
    .chip_sel_1_n_i(s1n), .chip_sel_2_i(s2), .chip_sel_3_n_i(s3n),
    .advance_or_load_i(adv), .write_n_i(wn), .byte_lane_write_n_i(ln),
    .burst_mode_i(bm), .addr_i(a), .out_enable_n_i(oen), .sleep_request_i(slp),
    .data_in_i(pins[DATA_W-1:0]), .data_out_o(dq[DATA_W-1:0]),
    .data_oe_o(doe[DATA_W-1:0]), .parity_io_in_i(pins[DATA_W+:LANES]),
    .parity_io_out_o(dq[DATA_W+:LANES]), .parity_io_oe_o(doe[DATA_W+:LANES]),
    .asleep_o(asl));
  ftsc_bus_model #(.W(W)) i_bus (.clk_i(clk_i), .drive_i(den), .ctl_i(wd),
    .dev_i(dq), .dev_oe_i(doe), .pins_o(pins));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [W-1:0] rv();
    return W'({$random(seed), $random(seed)});
  endfunction
  function automatic logic [W-1:0] mrg(input logic [W-1:0] o, v, input logic [LANES-1:0] l);
    for (int g = 0; g < LANES; g++) begin
      if (!l[g]) begin
        o[g*LANE_W+:LANE_W] = v[g*LANE_W+:LANE_W];
        o[DATA_W+g] = v[DATA_W+g];
      end
    end
    return o;
  endfunction
  task chk(input string n, input logic [W-1:0] x, input logic [W-1:0] g);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  // d picks which select is inactive, 0 selects the part
  task cyc(input int d, input logic ad, input logic w, input logic [LANES-1:0] l,
           input logic [ADDR_W-1:0] ar);
    @(posedge clk_i);
    s1n <= d == 1;
    s2 <= d != 2;
    s3n <= d == 3;
    adv <= ad;
    wn <= w;
    ln <= l;
    a <= ar;
  endtask
  task wr(input logic [ADDR_W-1:0] ar, input logic [LANES-1:0] l, input logic [W-1:0] v);
    cyc(0, 0, 0, l, ar);
    cyc(2, 0, 1, l, ar);
    den <= 1;
    wd <= v;
    cyc(0, 1, 1, '1, ar);
    den <= 0;
    mem[ar] = mrg(mem[ar], v, l);
  endtask
  task rd(input logic [ADDR_W-1:0] ar, input int k);
    logic [1:0] nb;
    cyc(0, 0, 1, '0, ar);
    if (!oen) q.push_back(mem[ar]);
    for (int j = 1; j < k; j++) begin
      cyc(0, 1, 0, '0, ~ar);
      nb = bm ? ar[1:0] ^ 2'(j) : ar[1:0] + 2'(j);
      if (!oen) q.push_back(mem[{ar[ADDR_W-1:2], nb}]);
    end
    cyc(3, 0, 1, '1, ar);
  endtask
  // Two-beat write burst; the write strobe is high on the second beat and must be ignored
  task wb(input logic [ADDR_W-1:0] ar, input logic [W-1:0] v0, input logic [W-1:0] v1);
    logic [1:0] nb;
    cyc(0, 0, 0, '0, ar);
    cyc(0, 1, 1, '0, ~ar);
    den <= 1;
    wd <= v0;
    cyc(3, 0, 1, '0, ar);
    wd <= v1;
    cyc(3, 0, 1, '1, ar);
    den <= 0;
    nb = bm ? ar[1:0] ^ 2'h1 : ar[1:0] + 2'h1;
    mem[ar] = v0;
    mem[{ar[ADDR_W-1:2], nb}] = v1;
  endtask
  task results();
    chk("queue", 0, W'(q.size()));
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Output watcher: any driven pin must match the oldest note
  // ----------------------------------------
  always @(negedge clk_i) begin
    if (doe !== '0) begin
      if (q.size() == 0) begin
        n_compared++;
        errors++;
        $display("mismatch data_out expected none seen %h", dq);
      end else begin
        e = q.pop_front();
        chk("data_oe", '1, doe);
        chk("data_out", e, dq);
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    for (i = 0; i < 8; i++) wr(ADDR_W'(i), '0, rv());
    $display("test full writes done");
    for (i = 0; i < 8; i++) wr(ADDR_W'(i), LANES'($random(seed)), rv());
    wr(ADDR_W'(3), '1, rv());
    $display("test lane writes done");
    rd(ADDR_W'(1), 4);
    bm <= 1;
    rd(ADDR_W'(6), 4);
    $display("test bursts done");
    wb(ADDR_W'(9), rv(), rv());
    rd(ADDR_W'(9), 2);
    $display("test burst write done");
    cyc(0, 0, 1, '0, ADDR_W'(5));
    q.push_back(mem[5]);
    cyc(0, 0, 1, '0, ADDR_W'(6));
    qn <= 1;
    q.push_back(mem[5]);
    cyc(3, 0, 1, '1, '0);
    qn <= 0;
    @(posedge clk_i);
    oen <= 1;
    rd(ADDR_W'(7), 2);
    @(posedge clk_i);
    oen <= 0;
    $display("test stall and enable done");
    slp <= 1;
    for (i = 0; i < 8 && asl !== 1'b1; i++) @(negedge clk_i);
    chk("asleep", 1, W'(asl));
    @(posedge clk_i);
    slp <= 0;
    for (i = 0; i < 8 && asl !== 1'b0; i++) @(negedge clk_i);
    chk("awake", 0, W'(asl));
    repeat (2) @(posedge clk_i);
    rd(ADDR_W'(2), 1);
    $display("test sleep done");
    repeat (2) @(negedge clk_i);
    results();
  end
endmodule
`default_nettype wire
